// [i2c_status_and_data_path_tb.sv]
`timescale 1ns/100ps
module i2c_status_and_data_path_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  int err_total, cmp_count;
  // open-drain lines with pull-ups
  wire scl_line = ~(scl_oe | scl_pull);
  wire sda_line = ~(sda_oe | sda_pull);
  i2csd_top i2csd_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl_i(scl_line),
    .scl_o, .scl_oe, .sda_i(sda_line), .sda_o, .sda_oe, .irq);
  i2csd_peer i2csd_peer_inst (.scl_pull, .sda_pull);
  // ==========
  // bus tasks; the leading edge keeps drivers from double assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // no cycle count assumed; only the watchdog ends a stalled wait
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    wr_r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // poll under a bounded count, since line events take many cycles
  task automatic poll(string nm, logic [7:0] a, m, e, int tries);
    for (int n = 0; n < tries; n++) begin
      rd(a);
      if ((rd_v[7:0] & m) === e) break;
    end
    chk(nm, rd_v[7:0] & m, e);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    conclude();
  end
  // ==========
  // tests
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    {err_total, cmp_count} = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    poll("status", i2csd_pkg::OFS_STAT, 8'hff, 8'h0a, 1);
    chk("rresp", {6'h0, rd_r}, 8'h00);
    poll("ctl2", i2csd_pkg::OFS_CTL2, 8'hfd, 8'h00, 1);
    rd(8'h1c);
    chk("unmapped", {6'h0, rd_r}, 8'h02);
    wr(8'h1c, 8'h00);
    chk("unmapped wr", {6'h0, wr_r}, 8'h02);
    $display("reset test done");
    wr(i2csd_pkg::OFS_CTL1, 8'hc0);
    chk("bresp", {6'h0, wr_r}, 8'h00);
    i2csd_peer_inst.start_cond();
    poll("busy", i2csd_pkg::OFS_CTL2, 8'h20, 8'h20, 20);
    wr(i2csd_pkg::OFS_CTL2, 8'h08);
    poll("arb", i2csd_pkg::OFS_CTL2, 8'h88, 8'h80, 20);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(i2csd_pkg::OFS_CTL2, 8'h00);
    poll("arb clr", i2csd_pkg::OFS_CTL2, 8'h80, 8'h00, 1);
    chk("irq", {7'h0, irq}, 8'h00);
    i2csd_peer_inst.stop_cond();
    poll("idle", i2csd_pkg::OFS_CTL2, 8'h20, 8'h00, 20);
    $display("arbitration test done");
    wr(i2csd_pkg::OFS_TXD, 8'h5a);
    poll("txe", i2csd_pkg::OFS_STAT, 8'h02, 8'h00, 1);
    wr(i2csd_pkg::OFS_ADDR, 8'h54);
    wr(i2csd_pkg::OFS_CTL2, 8'h08);
    poll("nack", i2csd_pkg::OFS_CTL2, 8'h48, 8'h40, 3000);
    chk("irq", {7'h0, irq}, 8'h01);
    poll("stop", i2csd_pkg::OFS_CTL2, 8'h20, 8'h00, 1000);
    poll("keep", i2csd_pkg::OFS_STAT, 8'h0a, 8'h08, 1);
    chk("lines", {4'h0, scl_o, sda_o, scl_oe, sda_oe}, 8'h00);
    poll("pec rdy", i2csd_pkg::OFS_STAT, 8'h04, 8'h04, 1);
    rd(i2csd_pkg::OFS_PEC);
    chk("pec", rd_v[7:0], 8'hab);
    poll("pec clr", i2csd_pkg::OFS_STAT, 8'h04, 8'h00, 1);
    wr(i2csd_pkg::OFS_TXD, rd_v[7:0]);
    $display("nack test done");
    wr(i2csd_pkg::OFS_CTL1, 8'h00);
    poll("dis st", i2csd_pkg::OFS_STAT, 8'hff, 8'h0a, 1);
    poll("dis c2", i2csd_pkg::OFS_CTL2, 8'hfd, 8'h00, 1);
    chk("irq", {7'h0, irq}, 8'h00);
    $display("disable test done");
    conclude();
  end
endmodule

// [i2csd_peer.sv]
`timescale 1ns/100ps
// ==========
// peer master: only frames the bus with start and stop
module i2csd_peer (
  output logic scl_pull,
  output logic sda_pull
);
  // released at rest; it drives no clock and holds scl low from start to stop
  initial begin
    scl_pull = 1'h0;
    sda_pull = 1'h0;
  end
  // start: sda falls while scl is high
  task automatic start_cond();
    #5 sda_pull = 1'h1;
    #80 scl_pull = 1'h1;
  endtask
  // stop: scl rises first, then sda rises
  task automatic stop_cond();
    #85 scl_pull = 1'h0;
    #80 sda_pull = 1'h0;
  endtask
endmodule

// [i2csd_pkg.sv]
package i2csd_pkg;
  // ==========================================================
  // timing: 50 mhz core clock, 100 khz bit clock when mastering
  localparam int CLK_MHZ = 50;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [8:0] SCL_HALF = 9'(SCL_HALF_CYC);

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_CTL2 = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_TXD = 8'h10;
  localparam logic [7:0] OFS_RXD = 8'h14;
  localparam logic [7:0] OFS_PEC = 8'h18;

  // ==========================================================
  // reset values and fixed codes
  localparam logic [7:0] OWN_ADDR_RST = 8'ha0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic RXAK_RST = 1'b1;
  localparam logic TXE_RST = 1'b1;
  localparam logic [6:0] GEN_CALL = 7'h00;
  localparam logic [6:0] EXT_CALL = 7'h0c;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // field positions
  localparam int A_EXT = 0;
  localparam int C1_EN = 7;
  localparam int C1_IEN = 6;
  localparam int C1_NOACK = 3;
  localparam int C1_PECB = 1;
  localparam int C2_AL = 7;
  localparam int C2_NAK = 6;
  localparam int C2_BB = 5;
  localparam int C2_MC = 3;
  localparam int C2_DIR = 2;
  localparam int C2_PECE = 1;

  // ==========================================================
  // master sequencer states
  typedef enum logic [1:0] {
    MST_IDLE = 2'b00,
    MST_START = 2'b01,
    MST_RUN = 2'b10,
    MST_STOP = 2'b11
  } i2csd_mst_t;
endpackage

// [i2csd_top.sv]
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module i2csd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  // ==========================================================
  // declarations
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic scl_d_ff, sda_d_ff, line_lo_ff;
  logic aw_hold_ff, w_hold_ff, w_lane_ff, awready_ff, wready_ff;
  logic bvalid_ff, arready_ff, rvalid_ff, irq_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] aw_addr_ff, wd, rd_byte;
  logic [31:0] w_data_ff, rdata_ff;
  logic [7:0] own_addr_ff;
  logic module_enable_ff, irq_enable_ff, noack_cfg_ff, pec_byte_ff;
  i2csd_pkg::i2csd_mst_t mst_ff;
  logic [8:0] tmr_ff;
  logic scl_oe_ff, sda_oe_ff, xmit_ff, act_ff, is_addr_ff, need_ff, pend_ff;
  logic [3:0] cnt_ff;
  logic [7:0] tx_sh_ff, rx_sh_ff, tx_data_ff, rx_data_ff, crc_ff, pec_val_ff;
  logic master_control_ff, master_direction_ff, bus_busy_ff;
  logic arb_loss_ff, no_ack_ff, pec_error_ff, rx_event_ff, tx_event_ff;
  logic addr_hit_ff, slave_dir_ff, rx_ack_ff, pec_ready_ff;
  logic tx_empty_ff, rx_full_ff;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic do_wr, wr_addr, wr_ctl1, wr_ctl2, wr_stat, wr_txd;
  logic rd_take, rd_rx, rd_pec, in_mst, addr_ok, ack_out, hold, stop_go;
  logic [7:0] crc_nxt;

  // ==========================================================
  // helpers
  function automatic logic is_mapped(input logic [7:0] a);
    return a == i2csd_pkg::OFS_ADDR || a == i2csd_pkg::OFS_CTL1 ||
           a == i2csd_pkg::OFS_CTL2 || a == i2csd_pkg::OFS_STAT ||
           a == i2csd_pkg::OFS_TXD || a == i2csd_pkg::OFS_RXD ||
           a == i2csd_pkg::OFS_PEC;
  endfunction

  // crc-8 over one byte, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ i2csd_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ==========================================================
  // pin synchronisers and line event detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sy_ff <= {scl_sy_ff[0], scl_i};
      sda_sy_ff <= {sda_sy_ff[0], sda_i};
      scl_d_ff <= scl_sy_ff[1];
      sda_d_ff <= sda_sy_ff[1];
    end
  end

  assign scl_s = scl_sy_ff[1];
  assign sda_s = sda_sy_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
  assign stop_det = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

  // ==========================================================
  // axi4-lite write channel: address and data taken in any order
  assign do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wd = w_data_ff[7:0];
  assign wr_addr = do_wr & w_lane_ff & (aw_addr_ff == i2csd_pkg::OFS_ADDR);
  assign wr_ctl1 = do_wr & w_lane_ff & (aw_addr_ff == i2csd_pkg::OFS_CTL1);
  assign wr_ctl2 = do_wr & w_lane_ff & (aw_addr_ff == i2csd_pkg::OFS_CTL2);
  assign wr_stat = do_wr & w_lane_ff & (aw_addr_ff == i2csd_pkg::OFS_STAT);
  assign wr_txd = do_wr & w_lane_ff & (aw_addr_ff == i2csd_pkg::OFS_TXD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= i2csd_pkg::BYTE_RST;
      w_data_ff <= 32'h0;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= i2csd_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready_ff) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= awaddr;
        awready_ff <= 1'b0;
      end
      if (wvalid && wready_ff) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= wdata;
        w_lane_ff <= wstrb[0];
        wready_ff <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= is_mapped(aw_addr_ff) ? i2csd_pkg::RESP_OKAY :
                    i2csd_pkg::RESP_SLVERR;
      end
      // channels reopen only after the response, one write at a time
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel with read side effects
  assign rd_take = arvalid & arready_ff;
  assign rd_rx = rd_take & (araddr == i2csd_pkg::OFS_RXD);
  assign rd_pec = rd_take & (araddr == i2csd_pkg::OFS_PEC);

  always_comb begin
    case (araddr)
      i2csd_pkg::OFS_ADDR: rd_byte = own_addr_ff;
      i2csd_pkg::OFS_CTL1: rd_byte = {module_enable_ff, irq_enable_ff,
                                      2'h0, noack_cfg_ff, 1'b0,
                                      pec_byte_ff, 1'b0};
      i2csd_pkg::OFS_CTL2: rd_byte = {arb_loss_ff, no_ack_ff, bus_busy_ff,
                                      1'b0, master_control_ff,
                                      master_direction_ff, pec_error_ff,
                                      1'b0};
      i2csd_pkg::OFS_STAT: rd_byte = {rx_event_ff, tx_event_ff,
                                      addr_hit_ff, slave_dir_ff, rx_ack_ff,
                                      pec_ready_ff, tx_empty_ff, rx_full_ff};
      i2csd_pkg::OFS_RXD: rd_byte = rx_data_ff;
      i2csd_pkg::OFS_PEC: rd_byte = pec_val_ff;
      default: rd_byte = i2csd_pkg::BYTE_RST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= i2csd_pkg::RESP_OKAY;
    end else if (rd_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h0, rd_byte};
      rresp_ff <= is_mapped(araddr) ? i2csd_pkg::RESP_OKAY :
                  i2csd_pkg::RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // software configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_addr_ff <= i2csd_pkg::OWN_ADDR_RST;
      module_enable_ff <= 1'b0;
      irq_enable_ff <= 1'b0;
      noack_cfg_ff <= 1'b0;
      pec_byte_ff <= 1'b0;
    end else begin
      if (wr_addr) begin
        own_addr_ff <= wd;
      end
      // a start ends the pec byte mode; a write in that cycle still wins
      if (start_det) begin
        pec_byte_ff <= 1'b0;
      end
      if (wr_ctl1) begin
        module_enable_ff <= wd[i2csd_pkg::C1_EN];
        irq_enable_ff <= wd[i2csd_pkg::C1_IEN];
        noack_cfg_ff <= wd[i2csd_pkg::C1_NOACK];
        pec_byte_ff <= wd[i2csd_pkg::C1_PECB];
      end
    end
  end

  // ==========================================================
  // byte engine terms
  assign in_mst = (mst_ff == i2csd_pkg::MST_RUN);
  assign addr_ok = (rx_sh_ff[7:1] == own_addr_ff[7:1]) ||
                   (own_addr_ff[i2csd_pkg::A_EXT] &&
                    (rx_sh_ff[7:1] == i2csd_pkg::GEN_CALL ||
                     rx_sh_ff[7:1] == i2csd_pkg::EXT_CALL));
  assign ack_out = is_addr_ff ? addr_ok : ~noack_cfg_ff;
  assign hold = pend_ff | (need_ff & tx_empty_ff);
  assign stop_go = ~master_control_ff & (cnt_ff == 4'h0);
  assign crc_nxt = crc8(crc_ff, rx_sh_ff);

  // ==========================================================
  // master sequencer, shifter and every status flag
  // flags are cleared by software first and set by hardware last, so an
  // event in the cycle of its clear is kept
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_enable_ff) begin
      mst_ff <= i2csd_pkg::MST_IDLE;
      tmr_ff <= 9'h0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      cnt_ff <= 4'h0;
      {xmit_ff, act_ff, is_addr_ff, need_ff, pend_ff} <= 5'h0;
      tx_sh_ff <= i2csd_pkg::BYTE_RST;
      rx_sh_ff <= i2csd_pkg::BYTE_RST;
      crc_ff <= i2csd_pkg::BYTE_RST;
      {master_control_ff, bus_busy_ff, arb_loss_ff, no_ack_ff} <= 4'h0;
      {rx_event_ff, tx_event_ff, addr_hit_ff, slave_dir_ff} <= 4'h0;
      {pec_ready_ff, rx_full_ff} <= 2'h0;
      rx_ack_ff <= i2csd_pkg::RXAK_RST;
      tx_empty_ff <= i2csd_pkg::TXE_RST;
      if (!aresetn) begin
        master_direction_ff <= 1'b0;
        tx_data_ff <= i2csd_pkg::BYTE_RST;
        rx_data_ff <= i2csd_pkg::BYTE_RST;
        pec_val_ff <= i2csd_pkg::BYTE_RST;
      end
    end else begin
      // bus state seen on the lines
      if (start_det) bus_busy_ff <= 1'b1;
      if (stop_det) bus_busy_ff <= 1'b0;
      // software side: clears by zero write, loads and reads
      if (wr_ctl2) begin
        if (!wd[i2csd_pkg::C2_AL]) arb_loss_ff <= 1'b0;
        if (!wd[i2csd_pkg::C2_NAK]) no_ack_ff <= 1'b0;
        master_direction_ff <= wd[i2csd_pkg::C2_DIR];
        if (!wd[i2csd_pkg::C2_MC]) begin
          master_control_ff <= 1'b0;
        end else if (!master_control_ff && bus_busy_ff) begin
          arb_loss_ff <= 1'b1;
        end else begin
          master_control_ff <= 1'b1;
        end
      end
      if (wr_stat && !wd[7]) rx_event_ff <= 1'b0;
      if (wr_stat && !wd[6]) tx_event_ff <= 1'b0;
      if (wr_txd) begin
        tx_data_ff <= wd;
        tx_empty_ff <= 1'b0;
      end
      if (rd_rx) rx_full_ff <= 1'b0;
      if (rd_pec) pec_ready_ff <= 1'b0;

      // master sequencer; a stretched low line pauses the high count
      case (mst_ff)
        i2csd_pkg::MST_IDLE: begin
          scl_oe_ff <= act_ff & hold & ~scl_s; // slave stretches
          if (master_control_ff && !bus_busy_ff && scl_s && sda_s) begin
            mst_ff <= i2csd_pkg::MST_START;
            sda_oe_ff <= 1'b1;
            tmr_ff <= i2csd_pkg::SCL_HALF;
          end
        end
        i2csd_pkg::MST_START: begin
          if (tmr_ff != 9'h0) begin
            tmr_ff <= tmr_ff - 9'h1;
          end else begin
            mst_ff <= i2csd_pkg::MST_RUN;
            scl_oe_ff <= 1'b1;
            tmr_ff <= i2csd_pkg::SCL_HALF;
            {xmit_ff, act_ff, is_addr_ff} <= 3'h7;
            cnt_ff <= 4'h0;
            crc_ff <= i2csd_pkg::BYTE_RST;
            tx_sh_ff <= {own_addr_ff[7:1], master_direction_ff};
          end
        end
        i2csd_pkg::MST_RUN: begin
          if (scl_oe_ff) begin
            if (tmr_ff != 9'h0) begin
              tmr_ff <= tmr_ff - 9'h1;
            end else if (stop_go) begin
              mst_ff <= i2csd_pkg::MST_STOP;
              sda_oe_ff <= 1'b1;
              need_ff <= 1'b0;
              tmr_ff <= i2csd_pkg::SCL_HALF;
            end else if (!hold) begin
              scl_oe_ff <= 1'b0;
              tmr_ff <= i2csd_pkg::SCL_HALF;
            end
          end else if (scl_s) begin
            if (tmr_ff != 9'h0) begin
              tmr_ff <= tmr_ff - 9'h1;
            end else begin
              scl_oe_ff <= 1'b1;
              tmr_ff <= i2csd_pkg::SCL_HALF;
            end
          end
        end
        i2csd_pkg::MST_STOP: begin
          if (tmr_ff != 9'h0) begin
            tmr_ff <= tmr_ff - 9'h1;
          end else if (scl_oe_ff) begin
            scl_oe_ff <= 1'b0;
            tmr_ff <= i2csd_pkg::SCL_HALF;
          end else if (scl_s) begin
            sda_oe_ff <= 1'b0; // sda rises with scl high: stop
            act_ff <= 1'b0;
            mst_ff <= i2csd_pkg::MST_IDLE;
          end
        end
        default: mst_ff <= i2csd_pkg::MST_IDLE;
      endcase

      // shifter: slave wake-up on a foreign start
      if (start_det && mst_ff == i2csd_pkg::MST_IDLE) begin
        {act_ff, is_addr_ff} <= 2'h3;
        {xmit_ff, need_ff} <= 2'h0;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
        crc_ff <= i2csd_pkg::BYTE_RST;
      end else if (act_ff && scl_rise && cnt_ff != i2csd_pkg::ACK_SLOT) begin
        rx_sh_ff <= {rx_sh_ff[6:0], sda_s};
        cnt_ff <= cnt_ff + 4'h1;
        // driven one but line low: lose, free both lines, stay a listener
        if (in_mst && xmit_ff && !sda_oe_ff && !sda_s) begin
          arb_loss_ff <= 1'b1;
          master_control_ff <= 1'b0;
          {scl_oe_ff, sda_oe_ff, xmit_ff} <= 3'h0;
          mst_ff <= i2csd_pkg::MST_IDLE;
        end
      end else if (act_ff && scl_rise) begin
        // ninth clock
        cnt_ff <= 4'h0;
        is_addr_ff <= 1'b0;
        crc_ff <= crc_nxt;
        pec_val_ff <= crc_nxt;
        pec_ready_ff <= 1'b1;
        if (xmit_ff) begin
          rx_ack_ff <= sda_s;
          if (sda_s && in_mst) begin
            no_ack_ff <= 1'b1;
            master_control_ff <= 1'b0;
          end else if (sda_s) begin
            act_ff <= 1'b0;
          end else if (in_mst && is_addr_ff && master_direction_ff) begin
            xmit_ff <= 1'b0;
          end else begin
            need_ff <= 1'b1;
          end
        end else if (is_addr_ff && !in_mst) begin
          if (addr_ok) begin
            addr_hit_ff <= 1'b1;
            slave_dir_ff <= rx_sh_ff[0];
            pend_ff <= 1'b1;
            xmit_ff <= rx_sh_ff[0];
            need_ff <= rx_sh_ff[0];
          end else begin
            act_ff <= 1'b0;
          end
        end else begin
          addr_hit_ff <= 1'b0;
          pend_ff <= 1'b1;
          if (pec_byte_ff) pec_error_ff <= (crc_nxt != 8'h00);
        end
      end else if (scl_fall && mst_ff != i2csd_pkg::MST_STOP) begin
        // new bit or ack goes out only while scl is low
        if (cnt_ff == i2csd_pkg::ACK_SLOT) begin
          sda_oe_ff <= act_ff & ~xmit_ff & ack_out;
        end else begin
          sda_oe_ff <= act_ff & xmit_ff & ~tx_sh_ff[~cnt_ff[2:0]];
        end
      end

      // received byte waits here while the previous one is unread
      if (pend_ff && !rx_full_ff) begin
        rx_data_ff <= rx_sh_ff;
        pend_ff <= 1'b0;
        rx_full_ff <= 1'b1;
        rx_event_ff <= 1'b1;
      end
      // tx data moves only with scl low so sda never changes under high
      if (need_ff && !tx_empty_ff && !scl_s && !scl_d_ff && !pend_ff) begin
        tx_sh_ff <= tx_data_ff;
        sda_oe_ff <= ~tx_data_ff[7];
        need_ff <= 1'b0;
        // a write landing in this cycle refills the register: it stays full
        tx_empty_ff <= ~wr_txd;
        tx_event_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // interrupt request and fixed low drive for the open-drain pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
      line_lo_ff <= 1'b0;
    end else begin
      irq_ff <= irq_enable_ff & (tx_event_ff | rx_event_ff |
                                 arb_loss_ff | no_ack_ff);
      line_lo_ff <= 1'b0;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bresp = bresp_ff;
  assign bvalid = bvalid_ff;
  assign arready = arready_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign rvalid = rvalid_ff;
  assign scl_o = line_lo_ff;
  assign sda_o = line_lo_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign irq = irq_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_al_busy;
    wr_ctl2 && module_enable_ff && wd[i2csd_pkg::C2_MC] &&
      !master_control_ff && bus_busy_ff |=> arb_loss_ff && !master_control_ff;
  endproperty
  a_al_busy: assert property (p_al_busy) else $error("no arb loss");

  property p_al_hold;
    arb_loss_ff && module_enable_ff && !wr_ctl2 |=> arb_loss_ff;
  endproperty
  a_al_hold: assert property (p_al_hold) else $error("arb lost");

  property p_nak_mc;
    $rose(no_ack_ff) |-> !master_control_ff;
  endproperty
  a_nak_mc: assert property (p_nak_mc) else $error("mc kept");

  property p_busy;
    start_det && module_enable_ff |=> bus_busy_ff;
  endproperty
  a_busy: assert property (p_busy) else $error("busy missed");

  property p_start;
    $rose(mst_ff == i2csd_pkg::MST_START) |-> sda_oe_ff && !scl_oe_ff;
  endproperty
  a_start: assert property (p_start) else $error("bad start");

  property p_rx_load;
    $rose(rx_full_ff) |-> rx_event_ff && $past(pend_ff);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx load");

  property p_rx_read;
    rd_rx && rx_full_ff && module_enable_ff |=> !rx_full_ff;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx full");

  property p_tx_wr;
    wr_txd && module_enable_ff |=> !tx_empty_ff ##1 1'b1;
  endproperty
  a_tx_wr: assert property (p_tx_wr) else $error("tx empty");

  property p_irq;
    irq_enable_ff && (rx_event_ff || arb_loss_ff) |=> irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_off;
    !module_enable_ff |=> tx_empty_ff && !rx_full_ff && !rx_event_ff;
  endproperty
  a_off: assert property (p_off) else $error("flags kept");

  c_rx: cover property ($rose(rx_full_ff));
  c_nak: cover property ($rose(no_ack_ff));
  c_run: cover property (mst_ff == i2csd_pkg::MST_RUN ##1 scl_oe_ff);
endmodule
